// file: hw/ascr_map.svh
`ifndef ASCR_MAP_SVH
`define ASCR_MAP_SVH

// Register page and offsets on the digital interface
`define ASCR_PAGE              4'h2
`define ASCR_OFS_OUT_STAGE     8'h3B
`define ASCR_OFS_BRIDGE        8'h46
`define ASCR_OFS_PGAIN         8'h47

// Non-volatile mirror addresses
`define ASCR_NV_OUT_STAGE      32'h4000_0021
`define ASCR_NV_BRIDGE         32'h4000_0022
`define ASCR_NV_PGAIN          32'h4000_0023

// Field positions
`define ASCR_OS_GAIN_LSB       0
`define ASCR_OS_LOOP_BIT       3
`define ASCR_OS_CAP_BIT        4
`define ASCR_OS_PULLUP_BIT     5
`define ASCR_BR_VSEL_LSB       1
`define ASCR_PG_CODE_LSB       0
`define ASCR_PG_INV_BIT        7

// Writable bit masks
`define ASCR_OS_MASK           8'h3F
`define ASCR_BR_MASK           8'h06
`define ASCR_PG_MASK           8'h9F

// Reset values
`define ASCR_OS_RESET          8'h05
`define ASCR_BR_RESET          8'h00
`define ASCR_PG_RESET          8'h00

`endif

// file: hw/ascr_pkg.sv
package ascr_pkg;
  typedef logic [7:0] ascr_byte_t;

  typedef enum logic [2:0] {
    ASCR_GAIN_OFF  = 3'b000,
    ASCR_GAIN_X10  = 3'b001,
    ASCR_GAIN_X4   = 3'b010,
    ASCR_GAIN_X2   = 3'b100,
    ASCR_GAIN_X667 = 3'b110
  } ascr_gain_t;

  typedef enum logic [1:0] {
    ASCR_VB_2V50 = 2'b00,
    ASCR_VB_2V00 = 2'b01,
    ASCR_VB_1V25 = 2'b10
  } ascr_vbridge_t;
endpackage

// file: hw/ascr_regs.sv
`timescale 1ns/100ps
`include "ascr_map.svh"

// Function
// - Output stage register at page 2 offset 3B, gain resets 101, switches off.
// - Gain code decodes off, 10, 4, 2, 6.67 V/V; other codes reserved.
// - Bit 3 set closes the current-loop switch, enabling the 4-20 mA loop.
// - Bit 4 set closes the output capacitor switch.
// - Bit 5 set closes the amplifier input pull-up switch.
// - Bridge supply register at page 2 offset 46, voltage field resets 00.
// - Bits 2:1 choose bridge voltage 2.5, 2.0 or 1.25 V.
// - Pressure gain register at page 2 offset 47, resets to zero.
// - Bits 4:0 form the pressure channel gain code.
// - Bit 7 set inverts the pressure gain amplifier output.
module ascr_regs (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_wr_en,
  input  wire logic                      i_rd_en,
  input  wire logic [3:0]                i_page,
  input  wire logic [7:0]                i_offset,
  input  wire ascr_pkg::ascr_byte_t      i_wdata,
  output ascr_pkg::ascr_byte_t           o_rdata,
  output logic                           o_rd_hit,
  output logic      [2:0]                o_gain_code,
  output logic                           o_gain_valid,
  output logic                           o_voltage_mode,
  output logic                           o_current_loop_enable,
  output logic                           o_output_cap_switch,
  output logic                           o_pullup_switch,
  output ascr_pkg::ascr_vbridge_t        o_bridge_voltage_select,
  output logic      [4:0]                o_pressure_gain_code,
  output logic                           o_pressure_polarity_invert
);
  import ascr_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] sel_of(input logic [3:0] pg,
                                        input logic [7:0] ofs);
    if (pg != `ASCR_PAGE) begin
      sel_of = 2'd0;
    end else if (ofs == `ASCR_OFS_OUT_STAGE) begin
      sel_of = 2'd1;
    end else if (ofs == `ASCR_OFS_BRIDGE) begin
      sel_of = 2'd2;
    end else if (ofs == `ASCR_OFS_PGAIN) begin
      sel_of = 2'd3;
    end else begin
      sel_of = 2'd0;
    end
  endfunction

  function automatic logic gain_ok(input logic [2:0] g);
    case (g)
      ASCR_GAIN_OFF, ASCR_GAIN_X10, ASCR_GAIN_X4,
      ASCR_GAIN_X2, ASCR_GAIN_X667: gain_ok = 1'b1;
      default:                      gain_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  ascr_byte_t os_reg, os_next;
  ascr_byte_t br_reg, br_next;
  ascr_byte_t pg_reg, pg_next;
  ascr_byte_t rdata_reg, rdata_next;
  logic       rd_hit_reg, rd_hit_next;
  logic [1:0] wsel;
  logic [1:0] rsel;

  always_comb begin
    wsel    = sel_of(i_page, i_offset);
    rsel    = wsel;
    os_next = os_reg;
    br_next = br_reg;
    pg_next = pg_reg;
    // Masked writes keep unused bits at zero
    if (i_wr_en && wsel == 2'd1) begin
      os_next = i_wdata & `ASCR_OS_MASK;
    end
    if (i_wr_en && wsel == 2'd2) begin
      br_next = i_wdata & `ASCR_BR_MASK;
    end
    if (i_wr_en && wsel == 2'd3) begin
      pg_next = i_wdata & `ASCR_PG_MASK;
    end
    rdata_next  = 8'h00;
    rd_hit_next = 1'b0;
    // Unmapped reads answer zero with no hit
    if (i_rd_en) begin
      rd_hit_next = (rsel != 2'd0);
      case (rsel)
        2'd1:    rdata_next = os_reg;
        2'd2:    rdata_next = br_reg;
        2'd3:    rdata_next = pg_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      os_reg     <= `ASCR_OS_RESET;
      br_reg     <= `ASCR_BR_RESET;
      pg_reg     <= `ASCR_PG_RESET;
      rdata_reg  <= 8'h00;
      rd_hit_reg <= 1'b0;
    end else begin
      os_reg     <= os_next;
      br_reg     <= br_next;
      pg_reg     <= pg_next;
      rdata_reg  <= rdata_next;
      rd_hit_reg <= rd_hit_next;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs, registered
  // ----------------------------------------------------------------
  logic [2:0]    gain_reg, gain_next;
  logic          gvalid_reg, gvalid_next;
  logic          vmode_reg, vmode_next;
  logic          loop_reg, loop_next;
  logic          cap_reg, cap_next;
  logic          pull_reg, pull_next;
  ascr_vbridge_t vb_reg, vb_next;
  logic [4:0]    pcode_reg, pcode_next;
  logic          pinv_reg, pinv_next;

  always_comb begin
    gain_next   = os_next[`ASCR_OS_GAIN_LSB +: 3];
    // Reserved codes flagged so the stage stays in a safe state
    gvalid_next = gain_ok(gain_next);
    vmode_next  = gvalid_next && (gain_next != ASCR_GAIN_OFF);
    loop_next   = os_next[`ASCR_OS_LOOP_BIT];
    cap_next    = os_next[`ASCR_OS_CAP_BIT];
    pull_next   = os_next[`ASCR_OS_PULLUP_BIT];
    // Codes 10 and 11 both give the lowest supply
    if (br_next[`ASCR_BR_VSEL_LSB + 1]) begin
      vb_next = ASCR_VB_1V25;
    end else if (br_next[`ASCR_BR_VSEL_LSB]) begin
      vb_next = ASCR_VB_2V00;
    end else begin
      vb_next = ASCR_VB_2V50;
    end
    pcode_next  = pg_next[`ASCR_PG_CODE_LSB +: 5];
    pinv_next   = pg_next[`ASCR_PG_INV_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      gain_reg   <= 3'(`ASCR_OS_RESET);
      gvalid_reg <= 1'b0;
      vmode_reg  <= 1'b0;
      loop_reg   <= 1'b0;
      cap_reg    <= 1'b0;
      pull_reg   <= 1'b0;
      vb_reg     <= ASCR_VB_2V50;
      pcode_reg  <= 5'h00;
      pinv_reg   <= 1'b0;
    end else begin
      gain_reg   <= gain_next;
      gvalid_reg <= gvalid_next;
      vmode_reg  <= vmode_next;
      loop_reg   <= loop_next;
      cap_reg    <= cap_next;
      pull_reg   <= pull_next;
      vb_reg     <= vb_next;
      pcode_reg  <= pcode_next;
      pinv_reg   <= pinv_next;
    end
  end

  assign o_rdata                    = rdata_reg;
  assign o_rd_hit                   = rd_hit_reg;
  assign o_gain_code                = gain_reg;
  assign o_gain_valid               = gvalid_reg;
  assign o_voltage_mode             = vmode_reg;
  assign o_current_loop_enable      = loop_reg;
  assign o_output_cap_switch        = cap_reg;
  assign o_pullup_switch            = pull_reg;
  assign o_bridge_voltage_select    = vb_reg;
  assign o_pressure_gain_code       = pcode_reg;
  assign o_pressure_polarity_invert = pinv_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_os_write;
    i_wr_en && i_page == `ASCR_PAGE && i_offset == `ASCR_OFS_OUT_STAGE;
  endsequence

  a_os_reset_value: assert property (@(posedge i_core_clk)
    !i_nrst |=> os_reg == 8'h05 && !loop_reg && !cap_reg && !pull_reg)
    else $error("output stage reset value wrong");
  a_gain_decode: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    o_gain_valid == (o_gain_code inside {3'b000, 3'b001, 3'b010,
                                         3'b100, 3'b110}) &&
    o_voltage_mode == (o_gain_valid && o_gain_code != 3'b000))
    else $error("reserved gain code marked valid");
  a_loop_follows: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    s_os_write |=> o_current_loop_enable == $past(i_wdata[3]))
    else $error("current loop switch not following write");
  a_cap_follows: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    s_os_write |=> o_output_cap_switch == $past(i_wdata[4]))
    else $error("capacitor switch not following write");
  a_pullup_follows: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    s_os_write |=> o_pullup_switch == $past(i_wdata[5]))
    else $error("pull-up switch not following write");
  a_bridge_reset: assert property (@(posedge i_core_clk)
    !i_nrst |=> br_reg == 8'h00 && o_bridge_voltage_select == ASCR_VB_2V50)
    else $error("bridge reset value wrong");
  a_bridge_decode: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    o_bridge_voltage_select == (br_reg[2] ? ASCR_VB_1V25 :
                                br_reg[1] ? ASCR_VB_2V00 : ASCR_VB_2V50))
    else $error("bridge voltage decode wrong");
  a_pgain_reset: assert property (@(posedge i_core_clk)
    !i_nrst |=> pg_reg == 8'h00)
    else $error("pressure gain reset value wrong");
  a_pgain_code: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    o_pressure_gain_code == pg_reg[`ASCR_PG_CODE_LSB +: 5])
    else $error("pressure gain code mismatch");
  a_pgain_write: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    i_wr_en && i_page == `ASCR_PAGE && i_offset == `ASCR_OFS_PGAIN
    |=> o_pressure_gain_code == $past(i_wdata[4:0]))
    else $error("pressure gain code not following write");
  a_pinv_follows: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    i_wr_en && i_page == `ASCR_PAGE && i_offset == `ASCR_OFS_PGAIN
    |=> o_pressure_polarity_invert == $past(i_wdata[7]))
    else $error("pressure invert not following write");
  a_unused_zero: assert property (@(posedge i_core_clk)
    disable iff (!i_nrst)
    o_rd_hit |-> (o_rdata & ~(`ASCR_OS_MASK | `ASCR_BR_MASK |
      `ASCR_PG_MASK)) == 8'h00 && os_reg[7:6] == 2'b00 &&
      br_reg[0] == 1'b0 && pg_reg[6:5] == 2'b00)
    else $error("unused bits not zero");
endmodule

// file: tb/ascr_regs_tb_top.sv
`timescale 1ns/100ps
`include "ascr_map.svh"
module ascr_regs_tb_top;
  import ascr_pkg::*;
  logic          i_core_clk = 1'b0;
  logic          i_nrst     = 1'b0;
  logic          i_wr_en    = 1'b0;
  logic          i_rd_en    = 1'b0;
  logic [3:0]    i_page     = 4'h0;
  logic [7:0]    i_offset   = 8'h00;
  ascr_byte_t    i_wdata    = 8'h00;
  ascr_byte_t    o_rdata;
  logic          o_rd_hit, o_gain_valid, o_voltage_mode;
  logic          o_current_loop_enable, o_output_cap_switch;
  logic          o_pullup_switch, o_pressure_polarity_invert;
  logic [2:0]    o_gain_code;
  logic [4:0]    o_pressure_gain_code;
  ascr_vbridge_t o_bridge_voltage_select;
  int            num_errors = 0;
  int            compares   = 0;
  int            os_m, br_m, pg_m;
  logic [7:0]    ofs_tab [6] = '{8'h3B, 8'h46, 8'h47, 8'h45, 8'h48, 8'hB3};

  always #2 i_core_clk = ~i_core_clk;

  ascr_regs i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_page(i_page),
    .i_offset(i_offset), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rd_hit(o_rd_hit), .o_gain_code(o_gain_code),
    .o_gain_valid(o_gain_valid), .o_voltage_mode(o_voltage_mode),
    .o_current_loop_enable(o_current_loop_enable),
    .o_output_cap_switch(o_output_cap_switch),
    .o_pullup_switch(o_pullup_switch),
    .o_bridge_voltage_select(o_bridge_voltage_select),
    .o_pressure_gain_code(o_pressure_gain_code),
    .o_pressure_polarity_invert(o_pressure_polarity_invert));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_outs;
    int   g;
    int   b;
    logic v;
    g = os_m & 7;
    v = (g != 3) && (g != 5) && (g != 7);
    b = (br_m >> 1) & 3;
    // Both top codes select the lowest bridge voltage
    if (b == 3) b = 2;
    check({5'b0, o_gain_code}, 8'(g));
    check({7'b0, o_gain_valid}, 8'(v));
    check({7'b0, o_voltage_mode}, 8'(v && g != 0));
    check({7'b0, o_current_loop_enable}, 8'(os_m >> 3 & 1));
    check({7'b0, o_output_cap_switch}, 8'(os_m >> 4 & 1));
    check({7'b0, o_pullup_switch}, 8'(os_m >> 5 & 1));
    check({6'b0, o_bridge_voltage_select}, 8'(b));
    check({3'b0, o_pressure_gain_code}, 8'(pg_m & 31));
    check({7'b0, o_pressure_polarity_invert}, 8'(pg_m >> 7));
  endtask

  // ----------------------------------------
  // Bus tasks; strobes stay up between back-to-back accesses
  // ----------------------------------------
  task automatic wr(input logic [3:0] pg, input logic [7:0] ofs,
                    input logic [7:0] d);
    i_wr_en = 1'b1;
    i_rd_en = 1'b0;
    i_page = pg;
    i_offset = ofs;
    i_wdata = d;
    @(posedge i_core_clk);
    #1;
    if (pg == `ASCR_PAGE && ofs == `ASCR_OFS_OUT_STAGE) os_m = d & 8'h3F;
    if (pg == `ASCR_PAGE && ofs == `ASCR_OFS_BRIDGE) br_m = d & 8'h06;
    if (pg == `ASCR_PAGE && ofs == `ASCR_OFS_PGAIN) pg_m = d & 8'h9F;
    check_outs();
  endtask

  task automatic rd(input logic [3:0] pg, input logic [7:0] ofs);
    int   e;
    logic h;
    i_rd_en = 1'b1;
    i_wr_en = 1'b0;
    i_page = pg;
    i_offset = ofs;
    @(posedge i_core_clk);
    #1;
    h = pg == 4'h2 && (ofs == 8'h3B || ofs == 8'h46 || ofs == 8'h47);
    e = !h ? 0 : ofs == 8'h3B ? os_m : ofs == 8'h46 ? br_m : pg_m;
    check(o_rdata, 8'(e));
    check({7'b0, o_rd_hit}, 8'(h));
  endtask

  task automatic idle;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    @(posedge i_core_clk);
    #1;
    check(o_rdata, 8'h00);
    check({7'b0, o_rd_hit}, 8'h00);
  endtask

  task automatic do_reset(input int n);
    i_nrst = 1'b0;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    repeat (n) @(posedge i_core_clk);
    #1;
    os_m = 8'h05;
    br_m = 0;
    pg_m = 0;
    check_outs();
    check(o_rdata, 8'h00);
    i_nrst = 1'b1;
    @(posedge i_core_clk);
    #1;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(32'hcf985892));
    do_reset(6);
    rd(4'h2, 8'h3B);
    rd(4'h2, 8'h46);
    rd(4'h2, 8'h47);
    for (int c = 0; c < 8; c++) begin
      wr(4'h2, 8'h3B, 8'(c) | 8'hF8);
      rd(4'h2, 8'h3B);
    end
    repeat (80) begin
      logic [3:0] pg;
      logic [7:0] ofs;
      pg = ($urandom % 4 == 0) ? 4'($urandom) : 4'h2;
      ofs = ofs_tab[$urandom % 6];
      if ($urandom % 2) wr(pg, ofs, 8'($urandom));
      else rd(pg, ofs);
    end
    idle();
    for (int c = 0; c < 4; c++) begin
      wr(4'h2, 8'h46, 8'(c << 1) | 8'hF9);
      rd(4'h2, 8'h46);
    end
    wr(4'h2, 8'h46, 8'hFF);
    wr(4'h2, 8'h47, 8'hFF);
    do_reset(1);
    rd(4'h2, 8'h47);
    idle();
    stop_test();
  end

  initial begin
    repeat (2000) @(posedge i_core_clk);
    num_errors++;
    stop_test();
  end
endmodule
